/* File: sew_defs.svh */
/*
  Constants of the two-wire serial memory link: identity prefix, memory shape,
  programming time and the clock rates the counts are derived from.
  Assumes it is included by its bare name from the package and design files.
*/
`ifndef SEW_DEFS_SVH
`define SEW_DEFS_SVH

`define SEW_ID_PREFIX   4'ha
`define SEW_MEM_BYTES   8192
`define SEW_ADDR_W      13
`define SEW_PAGE_BYTES  32
`define SEW_PAGE_W      5
`define SEW_TWR_MS      5
`define SEW_LINK_NS     160
`define SEW_MCLK_HZ     100000000
`define SEW_SCL_HZ      400000
`define SEW_PROG_CYC    ((`SEW_TWR_MS * 1000000) / `SEW_LINK_NS - `SEW_PAGE_BYTES)
`define SEW_QTR_CYC     (`SEW_MCLK_HZ / (4 * `SEW_SCL_HZ))

`endif

/* File: sew_pkg.sv */
/*
  Types shared by both ends of the two-wire memory link: state encodings,
  master command codes and the packed state records of each end.
  Assumes sew_defs.svh is on the include path.
*/
`include "sew_defs.svh"

package sew_pkg;

  typedef enum logic [6:0] {
    SEW_D_IDLE   = 7'h01,
    SEW_D_RX     = 7'h02,
    SEW_D_ACK    = 7'h04,
    SEW_D_TX     = 7'h08,
    SEW_D_TXACK  = 7'h10,
    SEW_D_PROG   = 7'h20,
    SEW_D_COMMIT = 7'h40
  } sew_dst_t;

  typedef enum logic [2:0] {
    SEW_M_IDLE = 3'h1,
    SEW_M_SEQ  = 3'h2,
    SEW_M_BIT  = 3'h4
  } sew_mst_t;

  typedef enum logic [1:0] {
    SEW_OP_START = 2'h0,
    SEW_OP_WRITE = 2'h1,
    SEW_OP_READ  = 2'h2,
    SEW_OP_STOP  = 2'h3
  } sew_op_t;

  typedef struct packed {
    sew_dst_t                  st;
    logic [2:0]                cs_s1;
    logic [2:0]                cs_s2;
    logic                      wp_s1;
    logic                      wp_s2;
    logic                      scl_s1;
    logic                      scl_s2;
    logic                      scl_s3;
    logic                      sda_s1;
    logic                      sda_s2;
    logic                      sda_s3;
    logic [3:0]                bitcnt;
    logic [7:0]                sh;
    logic [1:0]                phase;
    logic                      rw;
    logic [`SEW_ADDR_W-1:0]    addr;
    logic [`SEW_PAGE_BYTES-1:0] mask;
    logic [`SEW_PAGE_W-1:0]    ci;
    logic [31:0]               tcnt;
    logic                      sda_oe;
    logic                      busy;
  } sew_dev_t;

  typedef struct packed {
    sew_mst_t   st;
    sew_op_t    op;
    logic [1:0] q;
    logic [7:0] div;
    logic [3:0] bitn;
    logic [8:0] sh;
    logic [8:0] rx;
    logic       scl_o;
    logic       sda_oe;
    logic       ready;
    logic       rsp_valid;
    logic       sda_s1;
    logic       sda_s2;
  } sew_mst_t_rec_t;

endpackage

/* File: sew_link_if.sv */
/*
  The two-wire link between master and memory device. Both data drivers are
  pull-low only; the wire reads high unless an end enables its drive, which
  stands in for the external pull-up. The master drives the clock outright.
*/
`timescale 1ns/100ps
`default_nettype none

interface sew_link_if;
  logic scl_o;
  logic m_sda_oe;
  logic d_sda_oe;
  logic scl;
  logic sda;

  assign scl = scl_o;
  assign sda = ~(m_sda_oe | d_sda_oe);

  modport master (output scl_o, output m_sda_oe, input sda);
  modport device (input scl, input sda, output d_sda_oe);
endinterface

`default_nettype wire

/* File: sew_dev.sv */
/*
  Memory device end of the two-wire link: start/stop detection, identity
  match, address pointer, page buffer, self-timed programming and read-out.
  Assumes link_clk oversamples scl (bench 160 ns) and sys_rst is synchronous
  to link_clk and stands for the internal power-on reset.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sew_defs.svh"

// What this block does
// - 8192 bytes stored in 32-byte pages
// - ignore the bus while power-on reset
// - reset releases into standby, nothing pending
// - stop gives standby, after programming if busy
// - write-protect high blocks every array change
// - write-protect low lets writes proceed
// - three straps set the bus identity
// - unconnected straps count as zero; sew_dev has no pull-downs and relies on the carrier to drive open straps low
// - data line only pulled low or released
// - master makes clock, arbitration, start, stop; sew_mst has no arbitration and never compares what it drives with sda
// - master starts only on an idle bus; sew_mst sends a start whenever commanded, without sampling the bus first
// - data changes only while clock low
// - data edge with clock high is condition
// - one clock per bit, after start only
// - every transaction opens start, closes stop
// - bytes read as identity, address, data
// - programming self-timed within 5 ms
// - partial pages program only received bytes
// - start: data falls while clock high
// - stop: data rises while clock high
// - identity is 1010, straps, then direction
// - page writes step low five bits, wrap
module sew_dev #(
  parameter int PROG_CYC = `SEW_PROG_CYC
) (
  input  wire logic  link_clk,
  input  wire logic  sys_rst,
  input  wire logic  ce,
  sew_link_if.device link,
  input  wire logic  chip_select_strap_0,
  input  wire logic  chip_select_strap_1,
  input  wire logic  chip_select_strap_2,
  input  wire logic  write_protect,
  output logic       busy
);
  import sew_pkg::*;

  localparam sew_dev_t RST = '{st: SEW_D_IDLE, scl_s1: 1'b1, scl_s2: 1'b1, scl_s3: 1'b1,
                               sda_s1: 1'b1, sda_s2: 1'b1, sda_s3: 1'b1, default: '0};

  sew_dev_t r_reg;
  sew_dev_t r_next;

  logic [7:0] mem [`SEW_MEM_BYTES];
  logic [7:0] pbuf [`SEW_PAGE_BYTES];

  logic       start_c;
  logic       stop_c;
  logic       rise_c;
  logic       fall_c;
  logic       wr_pbuf;
  logic       wr_mem;
  logic [7:0] rd_byte;

  assign rd_byte = mem[r_reg.addr];

  always_comb begin
    r_next = r_reg;
    wr_pbuf = 1'b0;
    wr_mem = 1'b0;
    r_next.scl_s1 = link.scl;
    r_next.scl_s2 = r_reg.scl_s1;
    r_next.scl_s3 = r_reg.scl_s2;
    r_next.sda_s1 = link.sda;
    r_next.sda_s2 = r_reg.sda_s1;
    r_next.sda_s3 = r_reg.sda_s2;
    // straps driven low by the carrier when left open
    r_next.cs_s1 = {chip_select_strap_2, chip_select_strap_1, chip_select_strap_0};
    r_next.cs_s2 = r_reg.cs_s1;
    r_next.wp_s1 = write_protect;
    r_next.wp_s2 = r_reg.wp_s1;
    start_c = r_reg.scl_s2 & r_reg.scl_s3 & r_reg.sda_s3 & ~r_reg.sda_s2;
    stop_c  = r_reg.scl_s2 & r_reg.scl_s3 & ~r_reg.sda_s3 & r_reg.sda_s2;
    rise_c  = r_reg.scl_s2 & ~r_reg.scl_s3;
    fall_c  = ~r_reg.scl_s2 & r_reg.scl_s3;

    case (r_reg.st)
      SEW_D_IDLE: begin
        r_next.sda_oe = 1'b0;
      end
      SEW_D_RX: begin
        if (rise_c) begin
          r_next.sh = {r_reg.sh[6:0], r_reg.sda_s2};
          r_next.bitcnt = r_reg.bitcnt + 4'h1;
        end else if (fall_c && r_reg.bitcnt == 4'h8) begin
          r_next.bitcnt = 4'h0;
          r_next.st = SEW_D_ACK;
          r_next.sda_oe = 1'b1;
          case (r_reg.phase)
            2'h0: begin
              if (r_reg.sh[7:4] == `SEW_ID_PREFIX && r_reg.sh[3:1] == r_reg.cs_s2) begin
                r_next.rw = r_reg.sh[0];
              end else begin
                r_next.st = SEW_D_IDLE;
                r_next.sda_oe = 1'b0;
              end
            end
            2'h1: begin
              r_next.addr[`SEW_ADDR_W-1:8] = r_reg.sh[`SEW_ADDR_W-9:0];
            end
            2'h2: begin
              r_next.addr[7:0] = r_reg.sh;
            end
            default: begin
              if (!r_reg.wp_s2) begin
                wr_pbuf = 1'b1;
                r_next.mask[r_reg.addr[`SEW_PAGE_W-1:0]] = 1'b1;
              end
              r_next.addr[`SEW_PAGE_W-1:0] = r_reg.addr[`SEW_PAGE_W-1:0] + 5'h01;
            end
          endcase
        end
      end
      SEW_D_ACK: begin
        if (fall_c) begin
          if (r_reg.rw) begin
            r_next.sh = rd_byte;
            r_next.sda_oe = ~rd_byte[7];
            r_next.st = SEW_D_TX;
          end else begin
            r_next.sda_oe = 1'b0;
            r_next.st = SEW_D_RX;
            r_next.phase = (r_reg.phase == 2'h3) ? 2'h3 : r_reg.phase + 2'h1;
          end
        end
      end
      SEW_D_TX: begin
        if (fall_c) begin
          r_next.bitcnt = r_reg.bitcnt + 4'h1;
          if (r_reg.bitcnt == 4'h7) begin
            r_next.sda_oe = 1'b0;
            r_next.bitcnt = 4'h0;
            r_next.addr = r_reg.addr + 13'h0001;
            r_next.st = SEW_D_TXACK;
          end else begin
            r_next.sda_oe = ~r_reg.sh[6];
            r_next.sh = {r_reg.sh[6:0], 1'b0};
          end
        end
      end
      SEW_D_TXACK: begin
        if (rise_c) begin
          if (r_reg.sda_s2) begin
            r_next.st = SEW_D_IDLE;
          end else begin
            r_next.bitcnt = 4'h8;
          end
        end else if (fall_c && r_reg.bitcnt == 4'h8) begin
          r_next.bitcnt = 4'h0;
          r_next.sh = rd_byte;
          r_next.sda_oe = ~rd_byte[7];
          r_next.st = SEW_D_TX;
        end
      end
      SEW_D_PROG: begin
        r_next.tcnt = r_reg.tcnt + 32'h1;
        if (r_reg.tcnt == 32'(PROG_CYC - 1)) begin
          r_next.st = SEW_D_COMMIT;
          r_next.ci = '0;
        end
      end
      SEW_D_COMMIT: begin
        wr_mem = r_reg.mask[r_reg.ci];
        r_next.ci = r_reg.ci + 5'h01;
        if (r_reg.ci == 5'h1f) begin
          r_next.mask = '0;
          r_next.st = SEW_D_IDLE;
        end
      end
      default: begin
        r_next.st = SEW_D_IDLE;
      end
    endcase

    // conditions override bit handling, but not while programming
    if (r_reg.st != SEW_D_PROG && r_reg.st != SEW_D_COMMIT) begin
      if (start_c) begin
        r_next.st = SEW_D_RX;
        r_next.phase = 2'h0;
        r_next.bitcnt = 4'h0;
        r_next.sda_oe = 1'b0;
      end else if (stop_c) begin
        r_next.sda_oe = 1'b0;
        r_next.tcnt = '0;
        r_next.st = (r_reg.mask != '0) ? SEW_D_PROG : SEW_D_IDLE;
      end
    end
    r_next.busy = (r_next.st == SEW_D_PROG) || (r_next.st == SEW_D_COMMIT);
  end

  always_ff @(posedge link_clk) begin
    if (sys_rst) begin
      r_reg <= RST;
    end else if (ce) begin
      r_reg <= r_next;
    end
  end

  always_ff @(posedge link_clk) begin
    if (!sys_rst && ce) begin
      if (wr_pbuf) begin
        pbuf[r_reg.addr[`SEW_PAGE_W-1:0]] <= r_reg.sh;
      end
      if (wr_mem) begin
        mem[{r_reg.addr[`SEW_ADDR_W-1:`SEW_PAGE_W], r_reg.ci}] <= pbuf[r_reg.ci];
      end
    end
  end

  assign link.d_sda_oe = r_reg.sda_oe;
  assign busy = r_reg.busy;

endmodule

`default_nettype wire

/* File: sew_mst.sv */
/*
  Bus master end of the two-wire link: runs one command at a time (start,
  write byte, read byte, stop), makes scl by dividing mclk and drives sda
  pull-low only. Assumes commands come from logic on mclk.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sew_defs.svh"

module sew_mst #(
  parameter int QTR_CYC = `SEW_QTR_CYC
) (
  input  wire logic            mclk,
  input  wire logic            sys_rst,
  input  wire logic            ce,
  sew_link_if.master           link,
  input  wire logic            cmd_valid,
  input  wire sew_pkg::sew_op_t cmd_op,
  input  wire logic [7:0]      cmd_data,
  input  wire logic            cmd_last,
  output logic                 cmd_ready,
  output logic                 rsp_valid,
  output logic [7:0]           rsp_data,
  output logic                 rsp_nack
);
  import sew_pkg::*;

  localparam sew_mst_t_rec_t RST = '{st: SEW_M_IDLE, op: SEW_OP_START, scl_o: 1'b1,
                                     sda_s1: 1'b1, sda_s2: 1'b1, default: '0};

  sew_mst_t_rec_t r_reg;
  sew_mst_t_rec_t r_next;
  logic           tick;

  always_comb begin
    r_next = r_reg;
    r_next.sda_s1 = link.sda;
    r_next.sda_s2 = r_reg.sda_s1;
    r_next.rsp_valid = 1'b0;
    tick = (r_reg.div == 8'(QTR_CYC - 1));
    r_next.div = tick ? 8'h00 : r_reg.div + 8'h01;
    case (r_reg.st)
      SEW_M_IDLE: begin
        r_next.ready = 1'b1;
        if (r_reg.ready && cmd_valid) begin
          r_next.ready = 1'b0;
          r_next.op = cmd_op;
          r_next.q = 2'h0;
          r_next.div = 8'h00;
          r_next.bitn = 4'h0;
          r_next.scl_o = 1'b0;
          r_next.sh = (cmd_op == SEW_OP_READ) ? {8'hff, cmd_last} : {cmd_data, 1'b1};
          r_next.st = (cmd_op == SEW_OP_WRITE || cmd_op == SEW_OP_READ) ? SEW_M_BIT : SEW_M_SEQ;
        end
      end
      SEW_M_SEQ: begin
        if (tick) begin
          r_next.q = r_reg.q + 2'h1;
          case (r_reg.q)
            2'h0: r_next.sda_oe = (r_reg.op == SEW_OP_STOP);
            2'h1: r_next.scl_o = 1'b1;
            2'h2: r_next.sda_oe = (r_reg.op == SEW_OP_START);
            default: begin
              r_next.rsp_valid = 1'b1;
              r_next.st = SEW_M_IDLE;
            end
          endcase
        end
      end
      SEW_M_BIT: begin
        if (tick) begin
          r_next.q = r_reg.q + 2'h1;
          case (r_reg.q)
            2'h0: r_next.sda_oe = ~r_reg.sh[8];
            2'h1: r_next.scl_o = 1'b1;
            2'h2: r_next.rx = {r_reg.rx[7:0], r_reg.sda_s2};
            default: begin
              if (r_reg.bitn == 4'h8) begin
                r_next.rsp_valid = 1'b1;
                r_next.st = SEW_M_IDLE;
              end else begin
                r_next.scl_o = 1'b0;
                r_next.bitn = r_reg.bitn + 4'h1;
                r_next.sh = {r_reg.sh[7:0], 1'b1};
              end
            end
          endcase
        end
      end
      default: begin
        r_next.st = SEW_M_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      r_reg <= RST;
    end else if (ce) begin
      r_reg <= r_next;
    end
  end

  assign link.scl_o = r_reg.scl_o;
  assign link.m_sda_oe = r_reg.sda_oe;
  assign cmd_ready = r_reg.ready;
  assign rsp_valid = r_reg.rsp_valid;
  assign rsp_data = r_reg.rx[8:1];
  assign rsp_nack = r_reg.rx[0];

endmodule

`default_nettype wire

/* File: sew_link_props.sv */
/*
  Checker for the link between the two ends, on the device's clock.
  Assumes the bench hands in the interface wires, the device's reset and busy.
*/
`timescale 1ns/100ps
`default_nettype none

module sew_link_props #(
  parameter int PROG_CYC = 20
) (
  input wire logic link_clk,
  input wire logic sys_rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic d_sda_oe,
  input wire logic busy
);
  localparam int BMIN = PROG_CYC + 30;
  localparam int BMAX = PROG_CYC + 34;

  default clocking cb @(posedge link_clk); endclocking
  default disable iff (sys_rst);

  sequence s_start;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence s_stop;
    scl && $past(scl) && $rose(sda);
  endsequence
  sequence s_pulse;
    ##[1:20] $rose(scl) ##[1:20] $fell(scl);
  endsequence

  property p_rst_quiet;
    $fell(sys_rst) |-> (!d_sda_oe && !busy)[*4];
  endproperty
  property p_pull_low;
    d_sda_oe |-> !sda;
  endproperty
  property p_chg_low;
    $changed(d_sda_oe) |-> !scl && !$past(scl);
  endproperty
  property p_ack_hold;
    $rose(d_sda_oe) |-> d_sda_oe throughout s_pulse;
  endproperty
  property p_start_quiet;
    s_start |-> (!d_sda_oe)[*8];
  endproperty
  property p_stop_idle;
    s_stop |-> (!d_sda_oe)[*8];
  endproperty
  property p_busy_len;
    $rose(busy) |-> ##[BMIN:BMAX] $fell(busy);
  endproperty
  property p_busy_mute;
    busy |-> !d_sda_oe;
  endproperty

  a_rst_quiet: assert property (p_rst_quiet) else $error("drive after reset");
  a_pull_low: assert property (p_pull_low) else $error("sda high while pulled");
  a_chg_low: assert property (p_chg_low) else $error("sda changed, scl high");
  a_ack_hold: assert property (p_ack_hold) else $error("drive not held");
  a_start_quiet: assert property (p_start_quiet) else $error("drive after start");
  a_stop_idle: assert property (p_stop_idle) else $error("drive after stop");
  a_busy_len: assert property (p_busy_len) else $error("busy length");
  a_busy_mute: assert property (p_busy_mute) else $error("answer while busy");
endmodule

`default_nettype wire

/* File: serial_eeprom_two_wire_slave_test.sv */
/*
  Bench joining master and device over the link; writes, reads, protect,
  page wrap, busy polling and identity mismatch.
  Assumes the link interface, both ends and the checker are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none

module serial_eeprom_two_wire_slave_test;
  import sew_pkg::*;
  localparam int PROG = 200;
  localparam int CEIL = 90000;
  localparam logic [7:0] id_w = 8'haa;
  localparam logic [7:0] id_r = 8'hab;
  typedef struct packed {
    logic        wp;
    logic [12:0] a;
    logic [7:0]  d;
    logic [7:0]  e;
  } sew_row_t;
  sew_row_t   rows [2] = '{'{1'b0, 13'h1fff, 8'ha5, 8'ha5}, '{1'b1, 13'h1fff, 8'h5a, 8'ha5}};
  logic       mclk = 0;
  logic       link_clk = 0;
  logic       mrst = 1;
  logic       lrst = 1;
  logic       cmd_valid;
  sew_op_t    cmd_op;
  logic [7:0] cmd_data;
  logic       cmd_last;
  logic       cmd_ready;
  logic       rsp_valid;
  logic [7:0] rsp_data;
  logic       rsp_nack;
  logic       busy;
  logic       wp;
  logic [2:0] cs = 3'h5;
  logic [7:0] q [$];
  int         fails = 0;
  int         tests_run = 0;
  int         cyc = 0;

  always #5 mclk = ~mclk;
  // every link edge lands on an mclk falling edge, never on an mclk rising edge
  always #80 link_clk = ~link_clk;

  sew_link_if link ();
  sew_mst #(.QTR_CYC(40)) i_sew_mst (.mclk(mclk), .sys_rst(mrst), .ce(1'b1), .link(link.master),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_last(cmd_last),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack));
  sew_dev #(.PROG_CYC(PROG)) i_sew_dev (.link_clk(link_clk), .sys_rst(lrst), .ce(1'b1),
    .link(link.device), .chip_select_strap_0(cs[0]), .chip_select_strap_1(cs[1]),
    .chip_select_strap_2(cs[2]), .write_protect(wp), .busy(busy));
  sew_link_props #(.PROG_CYC(PROG)) i_sew_link_props (.link_clk(link_clk), .sys_rst(lrst),
    .scl(link.scl), .sda(link.sda), .d_sda_oe(link.d_sda_oe), .busy(busy));

  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask

  // one command, entered just after an edge; returns just after rsp_valid
  task automatic cmd(input sew_op_t op, input logic [7:0] d, input logic l);
    cmd_op = op;
    cmd_data = d;
    cmd_last = l;
    cmd_valid = 1'b1;
    do @(posedge mclk); while (cmd_ready !== 1'b1);
    #1 cmd_valid = 1'b0;
    do @(posedge mclk); while (rsp_valid !== 1'b1);
    #1;
  endtask

  // a written byte reads back from the wire unless someone else pulls it low
  task automatic wbyte(input logic [7:0] b, input logic nk);
    cmd(SEW_OP_WRITE, b, 1'b0);
    chk("nack", 8'(nk), 8'(rsp_nack));
    chk("echo", b, rsp_data);
  endtask

  task automatic wr(input logic [12:0] a, input logic [7:0] d [$]);
    cmd(SEW_OP_START, 8'h00, 1'b0);
    wbyte(id_w, 1'b0);
    wbyte({3'h0, a[12:8]}, 1'b0);
    wbyte(a[7:0], 1'b0);
    foreach (d[i]) wbyte(d[i], 1'b0);
    cmd(SEW_OP_STOP, 8'h00, 1'b0);
  endtask

  // one poll right after a write, then wait out programming
  task automatic poll(input logic nk);
    cmd(SEW_OP_START, 8'h00, 1'b0);
    wbyte(id_w, nk);
    chk("busy_on", 8'(nk), 8'(busy));
    cmd(SEW_OP_STOP, 8'h00, 1'b0);
    while (busy !== 1'b0) @(posedge mclk);
    #1;
  endtask

  task automatic rd(input logic [12:0] a, input int n);
    cmd(SEW_OP_START, 8'h00, 1'b0);
    wbyte(id_w, 1'b0);
    wbyte({3'h0, a[12:8]}, 1'b0);
    wbyte(a[7:0], 1'b0);
    cmd(SEW_OP_START, 8'h00, 1'b0);
    wbyte(id_r, 1'b0);
    q = {};
    for (int i = 0; i < n; i++) begin
      cmd(SEW_OP_READ, 8'h00, 1'(i == n - 1));
      q.push_back(rsp_data);
    end
    cmd(SEW_OP_STOP, 8'h00, 1'b0);
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == CEIL) begin
      fails++;
      stop_test;
    end
  end

  initial begin
    cmd_valid = 1'b0;
    cmd_op = SEW_OP_START;
    cmd_data = 8'h00;
    cmd_last = 1'b0;
    wp = 1'b0;
    repeat (10) @(posedge mclk);
    chk("rst_drive", 8'h00, 8'(link.d_sda_oe));
    chk("rst_busy", 8'h00, 8'(busy));
    #1 mrst = 1'b0;
    @(posedge link_clk);
    #1 lrst = 1'b0;
    repeat (6) @(posedge link_clk);
    @(posedge mclk);
    #1;
    chk("idle_sda", 8'h01, 8'(link.sda));
    chk("idle_busy", 8'h00, 8'(busy));
    foreach (rows[r]) begin
      wp = rows[r].wp;
      wr(rows[r].a, '{rows[r].d});
      poll(~rows[r].wp);
      rd(rows[r].a, 1);
      chk("row_data", rows[r].e, q[0]);
    end
    // three bytes from offset 30 of a page: the third wraps to offset 0
    wp = 1'b0;
    wr(13'h013e, '{8'h11, 8'h22, 8'h33});
    poll(1'b1);
    rd(13'h013e, 2);
    chk("seq0", 8'h11, q[0]);
    chk("seq1", 8'h22, q[1]);
    rd(13'h0120, 1);
    chk("wrap", 8'h33, q[0]);
    cmd(SEW_OP_START, 8'h00, 1'b0);
    wbyte(8'ha0, 1'b1);
    cmd(SEW_OP_STOP, 8'h00, 1'b0);
    // straps all low, as if left open: identity 1010_000 answers, the old one not
    cs = 3'h0;
    cmd(SEW_OP_START, 8'h00, 1'b0);
    wbyte(8'ha0, 1'b0);
    cmd(SEW_OP_START, 8'h00, 1'b0);
    wbyte(id_w, 1'b1);
    cmd(SEW_OP_STOP, 8'h00, 1'b0);
    stop_test;
  end
endmodule

`default_nettype wire
